/* hdl/dbgbk_pkg.sv */
// Package with constants for the debug breakpoint exception logic.
package dbgbk_pkg;
    // ------------------------------------------------------------
    // Register map (word offsets in bytes)
    // ------------------------------------------------------------
    localparam logic [5:0] OFF_BKADDR0 = 6'h00;
    localparam logic [5:0] OFF_BKADDR1 = 6'h04;
    localparam logic [5:0] OFF_BKADDR2 = 6'h08;
    localparam logic [5:0] OFF_BKADDR3 = 6'h0C;
    localparam logic [5:0] OFF_BKADDRHI = 6'h10;
    localparam logic [5:0] OFF_STATUS = 6'h18;
    localparam logic [5:0] OFF_CONTROL = 6'h1C;
    localparam logic [5:0] OFF_MODE = 6'h20;
    localparam logic [5:0] OFF_EXCINFO = 6'h24;
    localparam logic [5:0] OFF_RETLO = 6'h28;
    localparam logic [5:0] OFF_RETHI = 6'h2C;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int STS_TASK_HIT = 15;
    localparam int STS_GUARD_HIT = 13;
    localparam int CTL_GUARD = 13;
    localparam int CTL_TYPE_BASE = 16;
    localparam int MODE_DEBUG_EXT = 0;
    localparam int MODE_LONG = 1;
    // ------------------------------------------------------------
    // Reset values and encodings
    // ------------------------------------------------------------
    localparam logic [31:0] CONTROL_RESET = 32'h0000_0400;
    localparam logic [31:0] STATUS_RESET = 32'h0000_0000;
    localparam logic [7:0] DEBUG_VECTOR = 8'h01;
    localparam logic [1:0] TYPE_EXEC = 2'h0;
    localparam logic [1:0] TYPE_WRITE = 2'h1;
    localparam logic [1:0] TYPE_PORT = 2'h2;
    localparam logic [1:0] TYPE_RDWR = 2'h3;
    localparam logic [1:0] LEN_ONE = 2'h0;
    localparam logic [1:0] LEN_TWO = 2'h1;
    localparam logic [1:0] LEN_EIGHT = 2'h2;
    localparam logic [1:0] LEN_FOUR = 2'h3;
endpackage

/* hdl/dbgbk_unit.sv */
// Debug breakpoint detection and debug exception generation.
`timescale 1ns/100ps

module dbgbk_unit
    import dbgbk_pkg::*;
#(
    parameter int NUM_CMP = 4
) (
    // Clock and reset
    input wire logic mclk,
    input wire logic nrst,
    // Avalon-MM slave
    input wire logic [5:0] avsAddress,
    input wire logic avsRead,
    input wire logic avsWrite,
    input wire logic [31:0] avsWriteData,
    input wire logic [3:0] avsByteEnable,
    output logic [31:0] avsReadData,
    output logic avsWaitRequest,
    // Fetch stage, next instruction
    input wire logic fetchValid,
    input wire logic [63:0] fetchAddr,
    input wire logic resumeFlag,
    input wire logic regAccess,
    // Retire stage
    input wire logic retireValid,
    input wire logic [63:0] retireAddr,
    input wire logic [63:0] retireNextAddr,
    input wire logic repeatIncomplete,
    input wire logic memValid,
    input wire logic memWrite,
    input wire logic [63:0] memAddr,
    input wire logic [3:0] memSize,
    input wire logic portValid,
    input wire logic [15:0] portAddr,
    input wire logic [2:0] portSize,
    input wire logic taskSwitch,
    input wire logic taskTrap,
    // Exception outputs
    output logic excTake,
    output logic [7:0] excVector,
    output logic [63:0] excReturnAddr,
    output logic excBefore,
    output logic resumeClear
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [63:0] bkAddr [NUM_CMP];
    logic [31:0] control;
    logic [31:0] status;
    logic debugExt;
    logic longMode;
    logic [63:0] retAddr;
    logic excBeforeReg;
    logic [31:0] rdData;
    logic rdDone;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [63:0] lenMask(input logic [1:0] len);
        unique case (len)
            LEN_ONE: lenMask = 64'hFFFF_FFFF_FFFF_FFFF;
            LEN_TWO: lenMask = 64'hFFFF_FFFF_FFFF_FFFE;
            LEN_FOUR: lenMask = 64'hFFFF_FFFF_FFFF_FFFC;
            LEN_EIGHT: lenMask = 64'hFFFF_FFFF_FFFF_FFF8;
        endcase
    endfunction

    // Overlap of access [a, a+size) with the aligned range of the comparator.
    function automatic logic overlap(input logic [63:0] base, input logic [1:0] len,
                                     input logic [63:0] a, input logic [3:0] size);
        logic [63:0] lo;
        logic [63:0] hi;
        logic [63:0] last;
        lo = base & lenMask(len);
        hi = lo | ~lenMask(len);
        last = a + {60'h0, size} - 64'h1;
        overlap = (size != 4'h0) && (a <= hi) && (last >= lo);
    endfunction

    function automatic logic [1:0] typeOf(input logic [31:0] ctl, input int n);
        typeOf = ctl[CTL_TYPE_BASE + 4 * n +: 2];
    endfunction

    function automatic logic [1:0] lenOf(input logic [31:0] ctl, input int n);
        lenOf = ctl[CTL_TYPE_BASE + 4 * n + 2 +: 2];
    endfunction

    // ------------------------------------------------------------
    // Match logic
    // ------------------------------------------------------------
    logic [NUM_CMP-1:0] instHit;
    logic [NUM_CMP-1:0] dataHit;
    logic guardHit;
    logic taskHit;
    logic afterHit;
    logic beforeHit;
    logic [63:0] portWide;
    logic [3:0] portBytes;

    always_comb begin
        portWide = {48'h0, portAddr};
        portBytes = {1'b0, portSize};
        instHit = '0;
        dataHit = '0;
        for (int n = 0; n < NUM_CMP; n++) begin
            if (control[2 * n] || control[2 * n + 1]) begin
                // Instruction compare is exact and only hits with the length set to one byte.
                if (typeOf(control, n) == TYPE_EXEC && lenOf(control, n) == LEN_ONE
                        && fetchValid && !resumeFlag
                        && fetchAddr == bkAddr[n]) begin
                    instHit[n] = 1'b1;
                end
                // Eight byte length only while long mode is active.
                if (memValid && retireValid && (lenOf(control, n) != LEN_EIGHT || longMode)
                        && ((typeOf(control, n) == TYPE_WRITE && memWrite)
                        || typeOf(control, n) == TYPE_RDWR)
                        && overlap(bkAddr[n], lenOf(control, n), memAddr, memSize)) begin
                    dataHit[n] = 1'b1;
                end
                if (portValid && retireValid && debugExt
                        && typeOf(control, n) == TYPE_PORT
                        && lenOf(control, n) != LEN_EIGHT
                        && overlap(bkAddr[n], lenOf(control, n), portWide, portBytes)) begin
                    dataHit[n] = 1'b1;
                end
            end
        end
        guardHit = fetchValid && regAccess && control[CTL_GUARD];
        taskHit = retireValid && taskSwitch && taskTrap;
        afterHit = (|dataHit) || taskHit;
        beforeHit = (|instHit) || guardHit;
    end

    // ------------------------------------------------------------
    // Exception generation
    // ------------------------------------------------------------
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            excTake <= 1'b0;
            excBeforeReg <= 1'b0;
            retAddr <= 64'h0;
        end else if (afterHit) begin
            // After-execution hits win over the next fetch.
            excTake <= 1'b1;
            excBeforeReg <= 1'b0;
            // Incomplete repeat loops return to the string instruction.
            retAddr <= repeatIncomplete ? retireAddr : retireNextAddr;
        end else if (beforeHit) begin
            excTake <= 1'b1;
            excBeforeReg <= 1'b1;
            retAddr <= fetchAddr;
        end else begin
            excTake <= 1'b0;
            excBeforeReg <= 1'b0;
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            resumeClear <= 1'b0;
        end else begin
            resumeClear <= resumeFlag && retireValid;
        end
    end

    assign excVector = DEBUG_VECTOR;
    assign excReturnAddr = retAddr;
    assign excBefore = excBeforeReg;

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    logic wrCycle;
    logic [31:0] wrMask;
    assign wrCycle = avsWrite && !avsRead;
    assign wrMask = {{8{avsByteEnable[3]}}, {8{avsByteEnable[2]}},
                     {8{avsByteEnable[1]}}, {8{avsByteEnable[0]}}};

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            for (int n = 0; n < NUM_CMP; n++) begin
                bkAddr[n] <= 64'h0;
            end
        end else if (wrCycle && !(control[CTL_GUARD] && avsAddress <= OFF_BKADDRHI)) begin
            for (int n = 0; n < NUM_CMP; n++) begin
                if (avsAddress == OFF_BKADDR0 + 6'(4 * n)) begin
                    bkAddr[n][31:0] <= (bkAddr[n][31:0] & ~wrMask) | (avsWriteData & wrMask);
                end
            end
            // High halves are set through one shared word for comparator zero only.
            if (avsAddress == OFF_BKADDRHI) begin
                bkAddr[0][63:32] <= (bkAddr[0][63:32] & ~wrMask) | (avsWriteData & wrMask);
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            control <= CONTROL_RESET;
        end else begin
            if (wrCycle && avsAddress == OFF_CONTROL) begin
                control <= (control & ~wrMask) | (avsWriteData & wrMask);
            end
            if (retireValid && taskSwitch) begin
                for (int n = 0; n < NUM_CMP; n++) begin
                    control[2 * n] <= 1'b0;
                end
            end
            if (beforeHit && !afterHit && guardHit) begin
                control[CTL_GUARD] <= 1'b0;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (!nrst) begin
            debugExt <= 1'b0;
            longMode <= 1'b0;
        end else if (wrCycle && avsAddress == OFF_MODE && avsByteEnable[0]) begin
            debugExt <= avsWriteData[MODE_DEBUG_EXT];
            longMode <= avsWriteData[MODE_LONG];
        end
    end

    // Software clears by writing zero; hardware set wins.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            status <= STATUS_RESET;
        end else begin
            logic [31:0] setBits;
            setBits = 32'h0;
            if (afterHit) begin
                setBits[NUM_CMP-1:0] = dataHit;
                setBits[STS_TASK_HIT] = taskHit;
            end else if (beforeHit) begin
                setBits[NUM_CMP-1:0] = instHit;
                setBits[STS_GUARD_HIT] = guardHit;
            end
            if (wrCycle && avsAddress == OFF_STATUS) begin
                status <= (status & (avsWriteData | ~wrMask)) | setBits;
            end else begin
                status <= status | setBits;
            end
        end
    end

    // Reads answer one cycle after the request.
    always_ff @(posedge mclk) begin
        if (!nrst) begin
            rdDone <= 1'b0;
            rdData <= 32'h0;
        end else begin
            rdDone <= avsRead && !rdDone;
            unique case (avsAddress)
                OFF_BKADDR0: rdData <= bkAddr[0][31:0];
                OFF_BKADDR1: rdData <= bkAddr[1][31:0];
                OFF_BKADDR2: rdData <= bkAddr[2][31:0];
                OFF_BKADDR3: rdData <= bkAddr[3][31:0];
                OFF_BKADDRHI: rdData <= bkAddr[0][63:32];
                OFF_STATUS: rdData <= status;
                OFF_CONTROL: rdData <= control;
                OFF_MODE: rdData <= {30'h0, longMode, debugExt};
                OFF_EXCINFO: rdData <= {23'h0, excBeforeReg, excVector};
                OFF_RETLO: rdData <= retAddr[31:0];
                OFF_RETHI: rdData <= retAddr[63:32];
                default: rdData <= 32'h0;
            endcase
        end
    end

    assign avsReadData = rdData;
    assign avsWaitRequest = avsRead && !rdDone;
endmodule

/* verif/dbgbk_monitor.sv */
// Port assertions for the debug breakpoint exception logic.
`timescale 1ns/100ps
module dbgbk_monitor #(
    parameter int NUM_CMP = 4
) (
    input wire logic mclk,
    input wire logic nrst,
    input wire logic fetchValid, resumeFlag, regAccess, retireValid, repeatIncomplete,
    input wire logic taskSwitch, taskTrap, excTake, excBefore, resumeClear,
    input wire logic [7:0] excVector,
    input wire logic [63:0] fetchAddr, retireAddr, retireNextAddr, excReturnAddr
);
    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking @(posedge mclk); endclocking
    default disable iff (!nrst);
    vector_one_a: assert property (excTake |-> excVector == 8'h01)
        else $error("debug exception used a wrong vector");
    exc_cause_a: assert property (excTake |-> $past(fetchValid || retireValid))
        else $error("exception without a fetch or retire cause");
    before_ret_a: assert property (excTake && excBefore |->
        $past(fetchValid) && excReturnAddr == $past(fetchAddr))
        else $error("before-hit return address differs from fetch address");
    after_ret_a: assert property (excTake && !excBefore && !$past(repeatIncomplete) |->
        $past(retireValid) && excReturnAddr == $past(retireNextAddr))
        else $error("after-hit return address differs from next address");
    rep_ret_a: assert property (excTake && !excBefore && $past(repeatIncomplete) |->
        excReturnAddr == $past(retireAddr))
        else $error("repeat hit return address differs from instruction address");
    resume_mask_a: assert property (excTake && excBefore && !$past(regAccess) |->
        !$past(resumeFlag))
        else $error("instruction hit taken while resume flag set");
    task_hit_a: assert property ($past(retireValid && taskSwitch && taskTrap) |->
        excTake && !excBefore)
        else $error("trapped task switch gave no after-hit");
    resume_clr_a: assert property (resumeClear |-> $past(retireValid && resumeFlag))
        else $error("resume clear without a retiring instruction");
    cover property (excTake && excBefore);
    cover property (excTake && !excBefore);
    cover property (resumeClear);
endmodule

/* verif/dbgbk_pipe_model.sv */
// Execution pipeline model that feeds fetch and retire traffic to the breakpoint logic.
`timescale 1ns/100ps
module dbgbk_pipe_model #(
    parameter logic [63:0] RET_PC = 64'h0000_0000_0000_2000
) (
    input wire logic mclk,
    output logic fetchValid, resumeFlag, regAccess, retireValid, repeatIncomplete,
    output logic memValid, memWrite, portValid, taskSwitch, taskTrap,
    output logic [63:0] fetchAddr, retireAddr, retireNextAddr, memAddr,
    output logic [3:0] memSize,
    output logic [15:0] portAddr,
    output logic [2:0] portSize
);
    // ------------------------------------------------------------
    // Traffic
    // ------------------------------------------------------------
    initial begin
        {fetchValid, resumeFlag, regAccess, retireValid, repeatIncomplete} = '0;
        {memValid, memWrite, portValid, taskSwitch, taskTrap} = '0;
        {fetchAddr, retireAddr, retireNextAddr, memAddr, memSize, portAddr, portSize} = '0;
    end
    // Kinds: 0 fetch, 1 read, 2 write, 3 port, 4 trapped switch, 5 guarded move, 6 retire.
    task automatic op(input logic [3:0] k, input logic [63:0] a, input logic [3:0] sz,
        input logic f);
        @(posedge mclk);
        fetchValid <= k == 4'h0 || k == 4'h5;
        fetchAddr <= a;
        resumeFlag <= (f && k == 4'h0) || k == 4'h6;
        regAccess <= k == 4'h5;
        retireValid <= k inside {4'h1, 4'h2, 4'h3, 4'h4, 4'h6};
        retireAddr <= RET_PC;
        retireNextAddr <= RET_PC + 64'h4;
        repeatIncomplete <= f && k != 4'h0;
        memValid <= k == 4'h1 || k == 4'h2;
        memWrite <= k == 4'h2;
        memAddr <= a;
        memSize <= sz;
        portValid <= k == 4'h3;
        portAddr <= a[15:0];
        portSize <= sz[2:0];
        taskSwitch <= k == 4'h4;
        taskTrap <= k == 4'h4;
        @(posedge mclk);
        {fetchValid, resumeFlag, regAccess, retireValid, repeatIncomplete} <= '0;
        {memValid, memWrite, portValid, taskSwitch, taskTrap} <= '0;
        fetchAddr <= ~a;
        memAddr <= ~a;
        portAddr <= ~a[15:0];
        @(negedge mclk);
    endtask
endmodule

/* verif/tb_top.sv */
// Self-checking testbench for the debug breakpoint exception logic.
`timescale 1ns/100ps
module tb_top import dbgbk_pkg::*;;
    localparam logic [63:0] PC = 64'h0000_0000_0000_2000;
    logic mclk = 1'h0;
    logic nrst = 1'h0;
    logic [5:0] avsAddress = 6'h00;
    logic avsRead = 1'h0;
    logic avsWrite = 1'h0;
    logic [31:0] avsWriteData = 32'h0000_0000;
    logic [31:0] avsReadData, rdData;
    logic avsWaitRequest, fetchValid, resumeFlag, regAccess, retireValid, repeatIncomplete;
    logic memValid, memWrite, portValid, taskSwitch, taskTrap, excTake, excBefore, resumeClear;
    logic [7:0] excVector;
    logic [63:0] fetchAddr, retireAddr, retireNextAddr, memAddr, excReturnAddr;
    logic [3:0] memSize;
    logic [15:0] portAddr;
    logic [2:0] portSize;
    int n_fail = 0;
    int comparisons = 0;
    always #10 mclk = ~mclk;
    dbgbk_unit #(.NUM_CMP(4)) dut (.mclk(mclk), .nrst(nrst), .avsAddress(avsAddress),
        .avsRead(avsRead), .avsWrite(avsWrite), .avsWriteData(avsWriteData),
        .avsByteEnable(4'hF), .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
        .fetchValid(fetchValid), .fetchAddr(fetchAddr), .resumeFlag(resumeFlag),
        .regAccess(regAccess), .retireValid(retireValid), .retireAddr(retireAddr),
        .retireNextAddr(retireNextAddr), .repeatIncomplete(repeatIncomplete),
        .memValid(memValid), .memWrite(memWrite), .memAddr(memAddr), .memSize(memSize),
        .portValid(portValid), .portAddr(portAddr), .portSize(portSize),
        .taskSwitch(taskSwitch), .taskTrap(taskTrap), .excTake(excTake),
        .excVector(excVector), .excReturnAddr(excReturnAddr), .excBefore(excBefore),
        .resumeClear(resumeClear));
    dbgbk_pipe_model #(.RET_PC(PC)) pipe (.mclk(mclk), .fetchValid(fetchValid),
        .resumeFlag(resumeFlag), .regAccess(regAccess), .retireValid(retireValid),
        .repeatIncomplete(repeatIncomplete), .memValid(memValid), .memWrite(memWrite),
        .portValid(portValid), .taskSwitch(taskSwitch), .taskTrap(taskTrap),
        .fetchAddr(fetchAddr), .retireAddr(retireAddr), .retireNextAddr(retireNextAddr),
        .memAddr(memAddr), .memSize(memSize), .portAddr(portAddr), .portSize(portSize));
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] ctl(input int n, input logic [1:0] ty, input logic [1:0] ln);
        return CONTROL_RESET | (32'h1 << (2 * n)) | ({28'h0, ln, ty} << (CTL_TYPE_BASE + 4 * n));
    endfunction
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
        @(posedge mclk);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= w;
        avsRead <= !w;
        do @(posedge mclk); while (avsWaitRequest !== 1'h0);
        rdData = avsReadData;
        avsWrite <= 1'h0;
        avsRead <= 1'h0;
    endtask
    task automatic rd(input logic [5:0] a, input logic [31:0] e);
        bus(1'h0, a, 32'h0000_0000);
        chk({32'h0, rdData}, {32'h0, e});
    endtask
    task automatic ex(input logic t, input logic b, input logic [63:0] r);
        chk({63'h0, excTake}, {63'h0, t});
        if (t) begin
            chk({56'h0, excVector}, 64'h1);
            chk({63'h0, excBefore}, {63'h0, b});
            chk(excReturnAddr, r);
        end
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_inst();
        rd(OFF_STATUS, STATUS_RESET);
        rd(6'h3C, 32'h0000_0000);
        bus(1'h1, OFF_BKADDR0, 32'h0000_1000);
        bus(1'h1, OFF_CONTROL, ctl(0, TYPE_EXEC, LEN_ONE));
        pipe.op(4'h0, 64'h1000, 4'h1, 1'h0);
        ex(1'h1, 1'h1, 64'h1000);
        rd(OFF_STATUS, 32'h0000_0001);
        pipe.op(4'h0, 64'h1000, 4'h1, 1'h1);
        ex(1'h0, 1'h0, 64'h0);
        pipe.op(4'h6, 64'h0, 4'h1, 1'h0);
        chk({63'h0, resumeClear}, 64'h1);
        $display("instruction test done");
    endtask
    task automatic t_data();
        bus(1'h1, OFF_BKADDR1, 32'h0000_F004);
        bus(1'h1, OFF_CONTROL, ctl(1, TYPE_WRITE, LEN_FOUR));
        pipe.op(4'h2, 64'hF005, 4'h4, 1'h0);
        ex(1'h1, 1'h0, PC + 64'h4);
        pipe.op(4'h1, 64'hF005, 4'h4, 1'h0);
        ex(1'h0, 1'h0, 64'h0);
        pipe.op(4'h2, 64'hEFFE, 4'h4, 1'h0);
        ex(1'h0, 1'h0, 64'h0);
        bus(1'h1, OFF_CONTROL, ctl(1, TYPE_RDWR, LEN_FOUR));
        pipe.op(4'h1, 64'hF003, 4'h2, 1'h0);
        ex(1'h1, 1'h0, PC + 64'h4);
        $display("data test done");
    endtask
    task automatic t_port();
        bus(1'h1, OFF_BKADDR2, 32'h0000_0080);
        bus(1'h1, OFF_CONTROL, ctl(2, TYPE_PORT, LEN_ONE));
        bus(1'h1, OFF_MODE, 32'h0000_0000);
        pipe.op(4'h3, 64'h80, 4'h1, 1'h0);
        ex(1'h0, 1'h0, 64'h0);
        bus(1'h1, OFF_MODE, 32'h0000_0001);
        pipe.op(4'h3, 64'h80, 4'h1, 1'h1);
        ex(1'h1, 1'h0, PC);
        $display("port test done");
    endtask
    task automatic t_task();
        bus(1'h1, OFF_STATUS, 32'h0000_0000);
        bus(1'h1, OFF_CONTROL, ctl(2, TYPE_PORT, LEN_ONE) | 32'h0000_0080);
        pipe.op(4'h4, 64'h0, 4'h1, 1'h0);
        ex(1'h1, 1'h0, PC + 64'h4);
        rd(OFF_STATUS, 32'h0000_8000);
        rd(OFF_CONTROL, (ctl(2, TYPE_PORT, LEN_ONE) & 32'hFFFF_FFEF) | 32'h0000_0080);
        $display("task test done");
    endtask
    task automatic t_guard();
        bus(1'h1, OFF_CONTROL, CONTROL_RESET | 32'h0000_2000);
        pipe.op(4'h5, 64'h3000, 4'h1, 1'h0);
        ex(1'h1, 1'h1, 64'h3000);
        rd(OFF_CONTROL, CONTROL_RESET);
        rd(OFF_STATUS, 32'h0000_A000);
        $display("guard test done");
    endtask
    task automatic tally_and_finish();
        $display("comparisons=%0d n_fail=%0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    initial begin
        repeat (2) @(posedge mclk);
        nrst <= 1'h1;
        t_inst();
        t_data();
        t_port();
        t_task();
        t_guard();
        tally_and_finish();
    end
    initial begin
        repeat (3000) @(posedge mclk);
        n_fail++;
        tally_and_finish();
    end
endmodule
bind dbgbk_unit dbgbk_monitor #(.NUM_CMP(NUM_CMP)) mon (.mclk(mclk), .nrst(nrst),
    .fetchValid(fetchValid), .resumeFlag(resumeFlag), .regAccess(regAccess),
    .retireValid(retireValid), .repeatIncomplete(repeatIncomplete), .taskSwitch(taskSwitch),
    .taskTrap(taskTrap), .excTake(excTake), .excBefore(excBefore), .resumeClear(resumeClear),
    .excVector(excVector), .fetchAddr(fetchAddr), .retireAddr(retireAddr),
    .retireNextAddr(retireNextAddr), .excReturnAddr(excReturnAddr));
